// *** rtl/nvsc_defines.svh ***
`ifndef NVSC_DEFINES_SVH
`define NVSC_DEFINES_SVH
`define NVSC_CLK_PERIOD_NS   8
`define NVSC_T_CYC_NS        250
`define NVSC_T_AS_NS         50
`define NVSC_T_WP_NS         150
`define NVSC_T_WR_NS         25
`define NVSC_T_ACC_NS        250
`define NVSC_T_STP_NS        100
`define NVSC_T_STC_MS        10
`define NVSC_T_RCP_NS        450
`define NVSC_T_RCC_NS        1200
`define NVSC_T_ARC_NS        750
`define NVSC_CEIL(ns)        (((ns) + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
`define NVSC_AS_CYC          `NVSC_CEIL(`NVSC_T_AS_NS)
`define NVSC_WP_CYC          `NVSC_CEIL(`NVSC_T_WP_NS)
`define NVSC_WR_CYC          `NVSC_CEIL(`NVSC_T_WR_NS)
`define NVSC_ACC_CYC         `NVSC_CEIL(`NVSC_T_ACC_NS)
`define NVSC_CYC_CYC         `NVSC_CEIL(`NVSC_T_CYC_NS)
`define NVSC_STP_CYC         `NVSC_CEIL(`NVSC_T_STP_NS)
`define NVSC_STC_CYC         `NVSC_CEIL(`NVSC_T_STC_MS * 1000000)
`define NVSC_RCP_CYC         `NVSC_CEIL(`NVSC_T_RCP_NS)
`define NVSC_RCC_CYC         `NVSC_CEIL(`NVSC_T_RCC_NS)
`define NVSC_ARC_CYC         `NVSC_CEIL(`NVSC_T_ARC_NS)
`endif

// *** rtl/nvsc_pkg.sv ***
package nvsc_pkg;
   typedef enum logic [3:0] {
      NVSC_OP_READ   = 4'h1,
      NVSC_OP_WRITE  = 4'h2,
      NVSC_OP_STORE  = 4'h4,
      NVSC_OP_RECALL = 4'h8
   } nvsc_op_t;
   typedef enum logic [5:0] {
      NVSC_IDLE   = 6'h01,
      NVSC_SETUP  = 6'h02,
      NVSC_PULSE  = 6'h04,
      NVSC_HOLD   = 6'h08,
      NVSC_WAIT   = 6'h10,
      NVSC_DONE   = 6'h20
   } nvsc_state_t;
endpackage

// *** rtl/nvsc_ctrl.sv ***
// Functional notes
// - Select low for access, else pins released
// - Write strobe high reads, low writes
// - Hold store high during power transitions
// - Wait 1200ns after recall start
`timescale 1ns/1ns
`include "nvsc_defines.svh"
module nvsc_ctrl
   import nvsc_pkg::*;
#(
   parameter int unsigned STC_CYCLES = `NVSC_STC_CYC
) (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 nrst,
   // User command port
   input  wire logic                 cmd_valid,
   input  wire nvsc_pkg::nvsc_op_t   cmd_op,
   input  wire logic [7:0]           cmd_addr,
   input  wire logic [3:0]           cmd_wdata,
   output logic                      cmd_ready,
   output logic                      rsp_valid,
   output logic [3:0]                rsp_rdata,
   // Device pins
   output logic [7:0]                word_addr,
   output logic                      sel_n,
   output logic                      wr_n,
   output logic                      store_n,
   output logic                      recall_n,
   input  wire logic [3:0]           nibble_pins_i,
   output logic [3:0]                nibble_pins_o,
   output logic                      nibble_pins_oe
);
   import nvsc_pkg::*;

   // Wide enough for the full store wait at the default clock rate
   localparam int unsigned CW = 24;

   typedef struct packed {
      // Sequencer
      nvsc_state_t   st;
      nvsc_op_t      op;
      logic [CW-1:0] cnt;
      // User side
      logic          ready;
      logic          rvalid;
      logic [3:0]    rdata;
      // Pin images
      logic [7:0]    addr;
      logic          sel_n;
      logic          wr_n;
      logic          store_n;
      logic          recall_n;
      logic [3:0]    dout;
      logic          oe;
   } nvsc_regs_t;

   nvsc_regs_t q_r;
   nvsc_regs_t q_nxt;

   // Counters run down to zero inclusive
   function automatic logic [CW-1:0] cyc(input int unsigned n);
      cyc = CW'(n - 1);
   endfunction

   always_comb begin
      q_nxt        = q_r;
      q_nxt.rvalid = 1'b0;

      case (q_r.st)
         NVSC_IDLE: begin
            // Requests arriving while busy are ignored
            if (cmd_valid && q_r.ready) begin
               q_nxt.ready = 1'b0;
               q_nxt.op    = cmd_op;
               q_nxt.addr  = cmd_addr;
               q_nxt.dout  = cmd_wdata;
               q_nxt.st    = NVSC_SETUP;
               case (cmd_op)
                  NVSC_OP_READ: begin
                     q_nxt.sel_n = 1'b0;
                     q_nxt.cnt   = cyc(`NVSC_ACC_CYC);
                     q_nxt.st    = NVSC_PULSE;
                  end

                  NVSC_OP_WRITE: begin
                     // Select held back so the device never drives into our data
                     q_nxt.cnt   = cyc(`NVSC_AS_CYC);
                  end

                  NVSC_OP_STORE: begin
                     // Recall kept high so the store is not inhibited
                     q_nxt.recall_n = 1'b1;
                     q_nxt.store_n  = 1'b0;
                     q_nxt.cnt      = cyc(`NVSC_STP_CYC);
                     q_nxt.st       = NVSC_PULSE;
                  end

                  default: begin
                     q_nxt.recall_n = 1'b0;
                     q_nxt.cnt      = cyc(`NVSC_RCP_CYC);
                     q_nxt.st       = NVSC_PULSE;
                  end
               endcase
            end
         end

         NVSC_SETUP: begin
            // Address settles before select and strobe fall together
            if (q_r.cnt == '0) begin
               q_nxt.sel_n = 1'b0;
               q_nxt.wr_n  = 1'b0;
               q_nxt.oe    = 1'b1;
               q_nxt.cnt   = cyc(`NVSC_WP_CYC);
               q_nxt.st    = NVSC_PULSE;
            end else begin
               q_nxt.cnt = q_r.cnt - 1'b1;
            end
         end

         NVSC_PULSE: begin
            // Strobes rise here, and select for reads; counts set the recovery
            if (q_r.cnt == '0) begin
               q_nxt.st = NVSC_HOLD;
               case (q_r.op)
                  NVSC_OP_READ: begin
                     // Sampled at the last cycle of the access window
                     q_nxt.rdata = nibble_pins_i;
                     q_nxt.sel_n = 1'b1;
                     q_nxt.cnt   = cyc(`NVSC_WR_CYC);
                  end

                  NVSC_OP_WRITE: begin
                     q_nxt.wr_n = 1'b1;
                     q_nxt.cnt  = cyc(`NVSC_WR_CYC);
                  end

                  NVSC_OP_STORE: begin
                     // Device finishes the store on its own
                     q_nxt.store_n = 1'b1;
                     q_nxt.cnt     = CW'(STC_CYCLES);
                  end

                  default: begin
                     // Wait covers the recall cycle and recalled-data access
                     q_nxt.recall_n = 1'b1;
                     q_nxt.cnt      = cyc(`NVSC_RCC_CYC - `NVSC_RCP_CYC);
                  end
               endcase
            end else begin
               q_nxt.cnt = q_r.cnt - 1'b1;
            end
         end

         NVSC_HOLD: begin
            // Drive ends one cycle after the strobe, before the device turns on
            q_nxt.oe = 1'b0;
            if (q_r.cnt == '0) begin
               q_nxt.sel_n = 1'b1;
               q_nxt.st    = NVSC_DONE;
            end else begin
               q_nxt.cnt = q_r.cnt - 1'b1;
            end
         end

         NVSC_DONE: begin
            // Ready returns with the response pulse
            q_nxt.rvalid = 1'b1;
            q_nxt.ready  = 1'b1;
            q_nxt.st     = NVSC_IDLE;
         end

         default: begin
            // Stray encoding falls back to idle
            q_nxt.st = NVSC_IDLE;
         end
      endcase
   end

   // Every output below is a flop image
   always_ff @(posedge clock) begin
      if (!nrst) begin
         q_r          <= '0;
         q_r.st       <= NVSC_IDLE;
         q_r.op       <= NVSC_OP_READ;
         q_r.ready    <= 1'b1;
         q_r.sel_n    <= 1'b1;
         q_r.wr_n     <= 1'b1;
         // Store held high so power-up starts no store
         q_r.store_n  <= 1'b1;
         q_r.recall_n <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   // User side
   assign cmd_ready      = q_r.ready;
   assign rsp_valid      = q_r.rvalid;
   assign rsp_rdata      = q_r.rdata;
   // Device pins
   assign word_addr      = q_r.addr;
   assign sel_n          = q_r.sel_n;
   assign wr_n           = q_r.wr_n;
   assign store_n        = q_r.store_n;
   assign recall_n       = q_r.recall_n;
   assign nibble_pins_o  = q_r.dout;
   assign nibble_pins_oe = q_r.oe;
endmodule

// *** tb/nvsc_ctrl_assertions.sv ***
`timescale 1ns/1ns
module nvsc_ctrl_assertions (
   // Clock, reset and user handshake
   input wire logic       clock,
   input wire logic       nrst,
   input wire logic       cmd_valid,
   input wire logic       cmd_ready,
   // Device pins
   input wire logic [7:0] word_addr,
   input wire logic       sel_n,
   input wire logic       wr_n,
   input wire logic       store_n,
   input wire logic       recall_n,
   input wire logic       nibble_pins_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // Cycles since the recall pulse fell, saturating
   logic [7:0] rc_cnt;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rc_cnt <= 8'h00;
      end else if ($fell(recall_n)) begin
         rc_cnt <= 8'h01;
      end else if (rc_cnt != 8'h00 && rc_cnt != 8'hFF) begin
         rc_cnt <= rc_cnt + 8'h01;
      end
   end
   sequence s_rec_lo;
      !recall_n [*8];
   endsequence
   sequence s_quiet;
      (sel_n && store_n) [*8];
   endsequence
   chk_oe_sel: assert property (
      nibble_pins_oe |-> !sel_n && store_n && recall_n) else $error("drive off select");
   chk_wr_drive: assert property (
      !wr_n |-> !sel_n && nibble_pins_oe) else $error("write strobe undriven");
   chk_addr_hold: assert property (
      !sel_n && !$past(sel_n) |-> $stable(word_addr)) else $error("address moved");
   chk_store_width: assert property (
      $fell(store_n) |=> !store_n [*3]) else $error("store pulse short");
   chk_recall_width: assert property (
      $fell(recall_n) |-> s_rec_lo) else $error("recall pulse short");
   chk_recall_gap: assert property (
      $rose(recall_n) |-> s_quiet) else $error("access after recall");
   chk_recall_cycle: assert property (
      !sel_n |-> (rc_cnt == 8'h00 || rc_cnt >= 8'h96)) else $error("select inside recall cycle");
   chk_store_wait: assert property (
      $rose(store_n) |-> (sel_n && recall_n) [*8]) else $error("access during store");
   chk_nv_excl: assert property (
      !recall_n |-> store_n) else $error("store and recall");
   chk_take_once: assert property (
      cmd_valid && cmd_ready |=> !cmd_ready) else $error("ready stayed");
endmodule
bind nvsc_ctrl nvsc_ctrl_assertions i_nvsc_ctrl_assertions (.*);

// *** tb/nvsc_dev.sv ***
`timescale 1ns/1ns
module nvsc_dev #(parameter int STORE_NS = 160) (
   // Device pins
   input wire logic [7:0] word_addr,
   input wire logic       sel_n, wr_n, store_n, recall_n,
   input wire logic [3:0] pins_in,
   output logic     [3:0] pins_out,
   output logic           pins_oe
);
   logic [3:0] ram [256];
   logic [3:0] nv [256];
   logic       storing = 1'b0;
   // Outputs turn on only some time after the strobe rises
   wire #10    wr_late = wr_n;
   initial foreach (nv[i]) nv[i] = 4'h0;
   initial foreach (ram[i]) ram[i] = 4'hA;
   always @(posedge wr_n) if (!sel_n && store_n && recall_n && !storing) ram[word_addr] = pins_in;
   // Store cutting a write leaves that word undefined
   always @(negedge store_n) if (!sel_n && !wr_n && recall_n && !storing) ram[word_addr] = 4'hX;
   always @(negedge store_n) begin
      // Glitch filter before any copy
      #20;
      if (!store_n && recall_n && !storing) begin
         storing = 1'b1;
         foreach (ram[i]) if (nv[i] !== ram[i]) nv[i] = ram[i];
         #(STORE_NS) storing = 1'b0;
      end
   end
   always @(negedge recall_n) if (!storing) foreach (nv[i]) ram[i] = nv[i];
   assign pins_oe = !sel_n && wr_n && wr_late && store_n && recall_n && !storing;
   // Released pins show the inverse, never a stale match
   assign pins_out = pins_oe ? ram[word_addr] : ~ram[word_addr];
endmodule

// *** tb/shadowed_sram_nv_store_recall_test.sv ***
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module shadowed_sram_nv_store_recall_test;
   import nvsc_pkg::*;
   logic       clock, nrst, cmd_valid, cmd_ready, rsp_valid, sel_n, wr_n, store_n, recall_n;
   logic       oe, dev_oe;
   nvsc_op_t   cmd_op;
   logic [7:0] cmd_addr, word_addr;
   logic [3:0] cmd_wdata, rsp_rdata, pins_o, dev_q, bus;
   int         num_errors = 0;
   int         compares = 0;
   assign bus = oe ? pins_o : dev_q;
   nvsc_ctrl #(.STC_CYCLES(20)) i_nvsc_ctrl (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .word_addr(word_addr), .sel_n(sel_n),
      .wr_n(wr_n), .store_n(store_n), .recall_n(recall_n), .nibble_pins_i(bus),
      .nibble_pins_o(pins_o), .nibble_pins_oe(oe));
   nvsc_dev #(.STORE_NS(160)) i_nvsc_dev (.word_addr(word_addr), .sel_n(sel_n), .wr_n(wr_n),
      .store_n(store_n), .recall_n(recall_n), .pins_in(bus), .pins_out(dev_q),
      .pins_oe(dev_oe));
   always #4 clock = ~clock;
   // Both sides driving the data pins at once
   always @(negedge clock) if (nrst && oe) `CHECK("bus fight", 1'b0, dev_oe)
   task automatic conclude();
      if (num_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic run(input nvsc_op_t op, input logic [7:0] a, input logic [3:0] d);
      int n;
      @(negedge clock);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      @(negedge clock);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 400) begin
         @(negedge clock);
         n++;
      end
      if (n >= 400) begin
         num_errors++;
         conclude();
      end
   endtask
   task automatic t_idle_pins();
      `CHECK("store idle", 1'b1, store_n)
      `CHECK("select idle", 1'b1, sel_n)
      `CHECK("ready idle", 1'b1, cmd_ready)
   endtask
   // Corner addresses 00 and FF plus 5A, each written with its own data, then read back
   task automatic t_write_read();
      logic [7:0] a [3] = '{8'h00, 8'hFF, 8'h5A};
      foreach (a[i]) run(NVSC_OP_WRITE, a[i], ~a[i][3:0]);
      foreach (a[i]) begin
         run(NVSC_OP_READ, a[i], 4'h0);
         `CHECK("rdata", ~a[i][3:0], rsp_rdata)
      end
   endtask
   task automatic t_store_recall();
      run(NVSC_OP_WRITE, 8'h10, 4'h3);
      run(NVSC_OP_STORE, 8'h00, 4'h0);
      `CHECK("nv word", 4'h3, i_nvsc_dev.nv[8'h10])
      `CHECK("nv 00", 4'hF, i_nvsc_dev.nv[8'h00])
      run(NVSC_OP_WRITE, 8'h10, 4'hC);
      run(NVSC_OP_RECALL, 8'h00, 4'h0);
      run(NVSC_OP_READ, 8'h10, 4'h0);
      `CHECK("recalled", 4'h3, rsp_rdata)
   endtask
   initial begin
      clock = 1'b0;
      nrst = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = NVSC_OP_READ;
      cmd_addr = 8'h00;
      cmd_wdata = 4'h0;
      repeat (3) @(negedge clock);
      nrst = 1'b1;
      t_idle_pins();
      t_write_read();
      t_store_recall();
      conclude();
   end
endmodule
